// ### pkg/rot_set_sleep_pkg.sv
// Package for the rotate, set-file and sleep execution block.
// Assumes a core with an 8-bit data path and a four-phase instruction cycle.
`default_nettype none
package rot_set_sleep_pkg;
	localparam int          DATA_W       = 8;
	localparam int          ADDR_W       = 12;
	localparam int          BANK_W       = 4;
	localparam int          FADDR_W      = 8;
	localparam int          INSTR_W      = 16;
	localparam logic [7:0]  ALL_ONES     = 8'hFF;
	localparam logic [15:0] SLEEP_CODE   = 16'h0003;
	localparam logic [5:0]  ROT_TOP      = 6'h10;
	localparam logic [6:0]  SET_ONES_TOP = 7'h34;
	localparam int          TOP6_LSB     = 10;
	localparam int          TOP7_LSB     = 9;
	localparam int          D_BIT        = 9;
	localparam int          A_BIT        = 8;
	localparam logic [3:0]  ACCESS_LO    = 4'h0;
	localparam logic [3:0]  ACCESS_HI    = 4'hF;
	localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
	localparam logic        PWR_DOWN_RST = 1'b1;
	localparam logic        TIME_OUT_RST = 1'b1;
	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} phase_e;
endpackage : rot_set_sleep_pkg
`default_nettype wire

// ### hw/rot_set_sleep_exec.sv
// Execution logic for rotate-right-no-carry, set-file-to-ones and sleep.
// Assumes the instruction word is steady for a whole cycle and file data is valid from Q2.
`default_nettype none
// Overview of operation
// - Rotate-right-no-carry moves every bit right by one with bit zero going to bit seven, to W when d is 0.
// - With d set to one the rotated value is written back into the addressed file register.
// - With d clear the rotated value goes to W and the file register is left untouched.
// - An access-bank bit of zero selects the access bank, otherwise the bank select register picks the bank.
// - Set-file writes all ones into the addressed register and touches no status flag.
// - Sleep clears the power-down flag.
// - Sleep sets the time-out flag.
// - Sleep clears the watchdog count and its postscaler.
// - Sleep halts the core and stops the oscillator, entering in Q4.
// - A watchdog wake-up from sleep clears the time-out flag.
module rot_set_sleep_exec
	import rot_set_sleep_pkg::*;
(
	input  wire logic                                  i_clk_sys,
	input  wire logic                                  i_nrst,
	input  wire logic [rot_set_sleep_pkg::INSTR_W-1:0] i_instr,
	input  wire logic                                  i_instr_valid,
	input  wire logic [rot_set_sleep_pkg::BANK_W-1:0]  i_bank_select_reg,
	input  wire logic [rot_set_sleep_pkg::DATA_W-1:0]  i_file_rdata,
	input  wire logic                                  i_wake_event,
	input  wire logic                                  i_wake_by_watchdog,
	output logic [rot_set_sleep_pkg::ADDR_W-1:0]       o_file_addr,
	output logic                                       o_file_re,
	output logic                                       o_file_we,
	output logic [rot_set_sleep_pkg::DATA_W-1:0]       o_file_wdata,
	output logic                                       o_w_we,
	output logic [rot_set_sleep_pkg::DATA_W-1:0]       o_w_wdata,
	output logic                                       o_watchdog_clear,
	output logic                                       o_osc_stop,
	output logic                                       o_sleeping,
	output logic                                       o_power_down_flag,
	output logic                                       o_time_out_flag,
	output logic [3:0]                                 o_phase
);
	import rot_set_sleep_pkg::*;

	phase_e             phase_reg;
	phase_e             phase_next;
	logic               sleep_reg;
	logic               pwr_down_reg;
	logic               tmo_reg;
	logic [ADDR_W-1:0]  addr_reg;
	logic [DATA_W-1:0]  wdata_reg;
	logic               fwe_reg;
	logic               wwe_reg;
	logic               wdc_reg;
	logic [DATA_W-1:0]  rot_reg;

	wire                is_rot   = i_instr[INSTR_W-1:TOP6_LSB] == ROT_TOP;
	wire                is_ones  = i_instr[INSTR_W-1:TOP7_LSB] == SET_ONES_TOP;
	wire                is_sleep = i_instr == SLEEP_CODE;
	wire                dest_f   = i_instr[D_BIT];
	wire                abit     = i_instr[A_BIT];
	wire [FADDR_W-1:0]  faddr    = i_instr[FADDR_W-1:0];
	wire [BANK_W-1:0]   acc_bank = (faddr < ACCESS_SPLIT) ? ACCESS_LO : ACCESS_HI;
	wire [BANK_W-1:0]   bank     = abit ? i_bank_select_reg : acc_bank;
	wire [ADDR_W-1:0]   eff_addr = {bank, faddr};
	wire [DATA_W-1:0]   rotated  = {i_file_rdata[0], i_file_rdata[DATA_W-1:1]};
	wire                run      = i_instr_valid & ~sleep_reg;
	wire                in_q4    = phase_reg == PH_Q4;
	wire                in_q3    = phase_reg == PH_Q3;
	wire                in_q2    = phase_reg == PH_Q2;
	wire                do_rot   = run & is_rot;
	wire                do_ones  = run & is_ones;
	wire                do_sleep = run & is_sleep;
	wire                wake     = sleep_reg & i_wake_event;

	always_comb begin
		unique case (phase_reg)
			PH_Q1:   phase_next = PH_Q2;
			PH_Q2:   phase_next = PH_Q3;
			PH_Q3:   phase_next = PH_Q4;
			PH_Q4:   phase_next = PH_Q1;
			default: phase_next = PH_Q1;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			phase_reg <= PH_Q1;
		end else if (!sleep_reg || wake) begin
			phase_reg <= sleep_reg ? PH_Q1 : phase_next;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			addr_reg <= '0;
			rot_reg  <= '0;
		end else if (in_q2 && (do_rot || do_ones)) begin
			addr_reg <= eff_addr;
			rot_reg  <= rotated;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			fwe_reg   <= 1'b0;
			wwe_reg   <= 1'b0;
			wdata_reg <= '0;
		end else begin
			fwe_reg   <= in_q3 & ((do_rot & dest_f) | do_ones);
			wwe_reg   <= in_q3 & do_rot & ~dest_f;
			wdata_reg <= do_ones ? ALL_ONES : rot_reg;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			sleep_reg <= 1'b0;
			pwr_down_reg <= PWR_DOWN_RST;
			tmo_reg      <= TIME_OUT_RST;
			wdc_reg   <= 1'b0;
		end else begin
			wdc_reg <= in_q3 & do_sleep;
			if (in_q4 && do_sleep) begin
				sleep_reg <= 1'b1;
				pwr_down_reg <= 1'b0;
				tmo_reg      <= 1'b1;
			end else if (wake) begin
				sleep_reg <= 1'b0;
				if (i_wake_by_watchdog) begin
					tmo_reg <= 1'b0;
				end
			end
		end
	end

	assign o_file_addr       = (in_q2 || in_q3) ? eff_addr : addr_reg;
	assign o_file_re         = in_q2 & do_rot;
	assign o_file_we         = fwe_reg;
	assign o_file_wdata      = wdata_reg;
	assign o_w_we            = wwe_reg;
	assign o_w_wdata         = wdata_reg;
	assign o_watchdog_clear  = wdc_reg;
	assign o_osc_stop        = sleep_reg;
	assign o_sleeping        = sleep_reg;
	assign o_power_down_flag = pwr_down_reg;
	assign o_time_out_flag   = tmo_reg;
	assign o_phase           = phase_reg;

	// Checks on the rotate path.
	a_rotate_to_w: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q3 && do_rot && !dest_f) |=> (o_w_we && !o_file_we && o_w_wdata == $past(rot_reg)))
		else $error("Rotate to W misrouted.");
	a_rotate_to_f: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q3 && do_rot && dest_f) |=> (o_file_we && !o_w_we))
		else $error("Rotate write-back missing.");
	a_rotate_value: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q2 && do_rot) |=> (rot_reg == {$past(i_file_rdata[0]), $past(i_file_rdata[DATA_W-1:1])}))
		else $error("Rotate value wrong.");
	a_rotate_read: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q2 && do_rot) |-> (o_file_re && o_file_addr == eff_addr))
		else $error("Rotate read missing.");
	a_read_in_q2: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_file_re |-> (in_q2 && is_rot))
		else $error("Stray file read.");
	a_rotate_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q3 && do_rot && dest_f) |=> (o_file_addr == $past(eff_addr)))
		else $error("Rotate write-back address wrong.");

	// Checks on set-file and bank selection.
	a_set_file_ones_op_ones: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q3 && do_ones) |=> (o_file_we && o_file_wdata == ALL_ONES && $stable(o_time_out_flag)))
		else $error("Set-file did not write ones.");
	a_set_no_w: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q3 && do_ones) |=> (!o_w_we && $stable(o_power_down_flag)))
		else $error("Set-file touched W or a flag.");
	a_set_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q3 && do_ones) |=> (o_file_addr == $past(eff_addr)))
		else $error("Set-file address wrong.");
	a_bank_access: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q2 && do_ones && !abit && faddr < ACCESS_SPLIT) |-> (o_file_addr[ADDR_W-1:FADDR_W] == ACCESS_LO))
		else $error("Access bank not used.");
	a_bank_high: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q2 && (do_rot || do_ones) && !abit && faddr >= ACCESS_SPLIT) |->
		(o_file_addr[ADDR_W-1:FADDR_W] == ACCESS_HI))
		else $error("Upper access bank not used.");
	a_bank_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q2 && (do_rot || do_ones) && abit) |-> (o_file_addr[ADDR_W-1:FADDR_W] == i_bank_select_reg))
		else $error("Bank select register ignored.");

	// Checks on sleep and wake.
	a_sleep_flags: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q4 && do_sleep) |=> (!o_power_down_flag && o_time_out_flag && o_sleeping))
		else $error("Sleep flags wrong.");
	a_sleep_timeout: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q4 && do_sleep) |=> o_time_out_flag)
		else $error("Sleep did not set time-out.");
	a_sleep_watchdog: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q3 && do_sleep) |=> o_watchdog_clear ##1 (o_osc_stop && !o_watchdog_clear))
		else $error("Watchdog not cleared before sleep.");
	a_clear_in_q4: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_watchdog_clear |-> (in_q4 && is_sleep))
		else $error("Stray watchdog clear.");
	a_sleep_enter: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(in_q4 && do_sleep) |=> (o_phase == PH_Q1 && o_osc_stop))
		else $error("Sleep entry wrong.");
	a_sleep_frozen: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(o_sleeping && !i_wake_event) |=> (o_sleeping && o_phase == PH_Q1 && $stable(o_power_down_flag)))
		else $error("Core ran while asleep.");
	a_sleep_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		o_sleeping |-> (!o_file_we && !o_w_we && !o_file_re && !o_watchdog_clear))
		else $error("Strobe while asleep.");
	a_watchdog_wake: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(wake && i_wake_by_watchdog) |=> (!o_time_out_flag && !o_sleeping && o_phase == PH_Q1))
		else $error("Watchdog wake did not clear time-out.");
	a_plain_wake: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(wake && !i_wake_by_watchdog) |=> (!o_sleeping && $stable(o_time_out_flag)))
		else $error("Plain wake changed time-out.");
	a_wake_power: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		wake |=> !o_power_down_flag)
		else $error("Power-down flag set by wake.");

	// Checks on decode and timing.
	a_set_file_ones_op_code: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(i_instr_valid && !o_sleeping && i_instr[INSTR_W-1:TOP7_LSB] == SET_ONES_TOP && o_phase == PH_Q3) |=>
		(o_file_we && o_file_wdata == ALL_ONES))
		else $error("Set-file code not decoded.");
	a_sleep_code: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(i_instr_valid && !o_sleeping && i_instr == SLEEP_CODE && o_phase == PH_Q3) |=>
		(o_watchdog_clear ##1 o_sleeping))
		else $error("Sleep code not decoded.");
	a_write_in_q4: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		(o_file_we || o_w_we) |-> in_q4)
		else $error("Write outside the last phase.");
	a_phase_onehot: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
		$onehot(o_phase))
		else $error("Phase not one-hot.");
endmodule : rot_set_sleep_exec
`default_nettype wire

// ### tb/tb_rot_set_sleep_exec.sv
// Testbench for the rotate, set-file and sleep execution block.
// Assumes the design holds its own assertions and runs a four-phase instruction cycle.
`default_nettype none
module tb_rot_set_sleep_exec;
	timeunit 1ns;
	timeprecision 1ps;
	import rot_set_sleep_pkg::*;
	logic        clk, nrst = 0, valid = 0, wk = 0, wkw = 0, pwr_exp = 1, tmo_exp = 1;
	logic [15:0] ins = 0;
	logic [3:0]  bank_sel = 0, ph;
	logic [7:0]  rd = 0, fwd, wwd;
	logic [11:0] fa;
	logic        fre, fwe, wwe, wdc, osc, slp, pwr, tmo;
	logic [31:0] lf = 32'hA8266872;
	int          failures = 0, n_tests = 0;
	rot_set_sleep_exec u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_instr(ins), .i_instr_valid(valid),
		.i_bank_select_reg(bank_sel), .i_file_rdata(rd), .i_wake_event(wk), .i_wake_by_watchdog(wkw),
		.o_file_addr(fa), .o_file_re(fre), .o_file_we(fwe), .o_file_wdata(fwd), .o_w_we(wwe),
		.o_w_wdata(wwd), .o_watchdog_clear(wdc), .o_osc_stop(osc), .o_sleeping(slp),
		.o_power_down_flag(pwr), .o_time_out_flag(tmo), .o_phase(ph));
	function automatic logic [31:0] nxt(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : nxt
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	task automatic op(input logic [15:0] c, input logic v);
		logic rot, stf, slc, d, w;
		logic [7:0] r;
		logic [11:0] ea;
		rot = v && c[15:10] == ROT_TOP;
		stf = v && c[15:9] == SET_ONES_TOP;
		slc = v && c == SLEEP_CODE;
		d = c[D_BIT];
		lf = nxt(lf);
		r = lf[7:0];
		w = lf[12];
		ea = c[A_BIT] ? {lf[11:8], c[7:0]} : {(c[7:0] < ACCESS_SPLIT) ? ACCESS_LO : ACCESS_HI, c[7:0]};
		while (ph !== PH_Q4) @(posedge clk) #1;
		@(posedge clk);
		ins <= c;
		valid <= v;
		rd <= r;
		bank_sel <= lf[11:8];
		@(posedge clk) #1;
		if (rot || stf) chk(fa, ea);
		chk(fre, rot);
		repeat (2) @(posedge clk);
		#1 chk(fwe, (rot && d) || stf);
		if ((rot && d) || stf) chk(fa, ea);
		chk(wwe, rot && !d);
		if (rot) chk(d ? fwd : wwd, {r[0], r[7:1]});
		if (stf) chk(fwd, ALL_ONES);
		chk(wdc, slc);
		chk({pwr, tmo}, {pwr_exp, tmo_exp});
		if (slc) begin
			@(posedge clk);
			ins <= 16'h0000;
			#1 chk({slp, osc}, 2'b11);
			chk({pwr, tmo}, 2'b01);
			repeat (3) @(posedge clk);
			#1 chk(ph, PH_Q1);
			@(posedge clk);
			wk <= 1;
			wkw <= w;
			@(posedge clk);
			wk <= 0;
			pwr_exp = 0;
			tmo_exp = !w;
			#1 chk({slp, tmo}, {1'b0, tmo_exp});
		end
	endtask : op
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	initial begin
		#20000;
		failures++;
		test_done;
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 chk({ph, pwr, tmo}, {PH_Q1, 2'b11});
		@(posedge clk);
		nrst <= 1;
		op({ROT_TOP, 2'b10, 8'h7F}, 1'b1);
		op({SET_ONES_TOP, 1'b0, 8'h80}, 1'b1);
		for (int i = 0; i < 40; i++) begin
			lf = nxt(lf);
			case (lf[14:13])
				2'd0: op({ROT_TOP, lf[17:16], lf[25:18]}, 1'b1);
				2'd1: op({SET_ONES_TOP, lf[16], lf[25:18]}, 1'b1);
				2'd2: op({ROT_TOP, lf[17:16], lf[25:18]}, 1'b0);
				default: op(SLEEP_CODE, 1'b1);
			endcase
		end
		test_done;
	end
endmodule : tb_rot_set_sleep_exec
`default_nettype wire
